// [hw/pci_ctl.sv]
`timescale 1ns/100ps
`default_nettype none
module pci_ctl
	import pci_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	pci_link_if.ctl          link
);
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] req;
		logic [31:0] val;
		logic [31:0] rsp;
		logic [31:0] rval;
		logic        busy;
		logic        done;
		logic        req_valid;
	} pci_ctl_s;

	pci_ctl_s st_ff;
	pci_ctl_s nxt_st;

	// Byte-lane merge honouring write strobes
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	// Bus slave, request launch and response capture
	always_comb begin
		nxt_st = st_ff;
		nxt_st.req_valid = 1'b0;
		if (s_axi_awvalid && st_ff.awready) begin
			nxt_st.awaddr = s_axi_awaddr;
			nxt_st.awready = 1'b0;
		end
		if (s_axi_wvalid && st_ff.wready) begin
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
			nxt_st.wready = 1'b0;
		end
		// Both halves held: perform the write once, then answer
		if (!st_ff.awready && !st_ff.wready && !st_ff.bvalid) begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = RESP_OK;
			case (st_ff.awaddr)
				OFS_REQ: nxt_st.req = merge(st_ff.req, st_ff.wdata, st_ff.wstrb);
				OFS_VAL: nxt_st.val = merge(st_ff.val, st_ff.wdata, st_ff.wstrb);
				OFS_CTRL: begin
					// Start ignored while a request is outstanding
					if (st_ff.wstrb[0] && st_ff.wdata[0] && !st_ff.busy) begin
						nxt_st.req_valid = 1'b1;
						nxt_st.busy = 1'b1;
						nxt_st.done = 1'b0;
					end
				end
				OFS_STAT, OFS_RSP, OFS_RVAL: nxt_st.bresp = RESP_OK;
				default: nxt_st.bresp = RESP_ERR;
			endcase
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
			nxt_st.awready = 1'b1;
			nxt_st.wready = 1'b1;
		end
		// Read channel: one read at a time
		if (s_axi_arvalid && st_ff.arready) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = RESP_OK;
			case (s_axi_araddr)
				OFS_REQ:  nxt_st.rdata = st_ff.req;
				OFS_VAL:  nxt_st.rdata = st_ff.val;
				OFS_CTRL: nxt_st.rdata = 32'h0000_0000;
				OFS_STAT: nxt_st.rdata = {30'h0000_0000, st_ff.done, st_ff.busy};
				OFS_RSP:  nxt_st.rdata = st_ff.rsp;
				OFS_RVAL: nxt_st.rdata = st_ff.rval;
				default: begin
					nxt_st.rdata = 32'h0000_0000;
					nxt_st.rresp = RESP_ERR;
				end
			endcase
		end
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end
		// Response capture ends the outstanding request
		if (link.resp_valid && st_ff.busy) begin
			nxt_st.rsp = {link.resp_words[1], link.resp_words[0]};
			nxt_st.rval = {link.resp_words[2], link.resp_words[3]};
			nxt_st.busy = 1'b0;
			nxt_st.done = 1'b1;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.awready <= 1'b1;
			st_ff.wready <= 1'b1;
			st_ff.arready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready = st_ff.wready;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign link.req_valid = st_ff.req_valid;
	// Reserved header bit forced low whatever software wrote
	assign link.req_words = {st_ff.val[15:0], st_ff.val[31:16], st_ff.req[31:16],
		st_ff.req[15:12], 1'b0, st_ff.req[10:0]};
endmodule : pci_ctl
`default_nettype wire

// [hw/pci_dev.sv]
`timescale 1ns/100ps
`default_nettype none
module pci_dev
	import pci_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        master_ctrl,
	output logic             par_changed,
	output logic [2:0]       par_num,
	output logic [1:0]       par_elem,
	output logic [31:0]      par_value,
	pci_link_if.dev          link
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_EXEC = 2'b10
	} pci_state_e;

	typedef struct packed {
		pci_state_e                          state;
		pci_chan_t                           req;
		pci_chan_t                           resp;
		logic                                resp_valid;
		logic                                changed;
		logic [2:0]                          num;
		logic [1:0]                          elem;
		logic [31:0]                         value;
		logic [1:0]                          mc_sync;
		logic [N_PARAM*N_ELEM-1:0][31:0]     mem;
	} pci_dev_s;

	pci_dev_s st_ff;
	pci_dev_s nxt_st;

	// Decoded request fields
	logic [3:0]  rq_id;
	logic [10:0] rq_pnu;
	logic [7:0]  rq_sub;
	logic [7:0]  rq_page;
	logic [2:0]  pidx;
	logic [1:0]  eidx;
	logic [31:0] cur;
	logic        is_dw;
	logic        is_ro;
	logic        bad_pnu;
	logic        bad_sub;

	// Field extraction, shared by all request kinds
	always_comb begin
		rq_id = pci_id(st_ff.req[0]);
		rq_pnu = pci_pnu(st_ff.req[0]);
		rq_sub = st_ff.req[1][15:SUB_LSB];
		rq_page = st_ff.req[1][SUB_LSB-1:0];
		pidx = rq_pnu[2:0];
		eidx = rq_sub[1:0];
		cur = st_ff.mem[{pidx, eidx}];
		is_dw = PAR_DW_MASK[pidx];
		is_ro = PAR_RO_MASK[pidx];
		// Only page zero holds the small parameter table
		bad_pnu = (rq_pnu >= 11'(N_PARAM)) || (rq_page != PAGE_BASE);
		bad_sub = rq_sub >= 8'(N_ELEM);
	end

	// Request decode and execution
	always_comb begin
		nxt_st = st_ff;
		nxt_st.resp_valid = 1'b0;
		nxt_st.changed = 1'b0;
		// Master control is a level from outside; two stages before use
		nxt_st.mc_sync = {st_ff.mc_sync[0], master_ctrl};
		case (st_ff.state)
			ST_IDLE: begin
				// A request only lands while idle; others are dropped
				if (link.req_valid) begin
					nxt_st.req = link.req_words;
					nxt_st.state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				nxt_st.state = ST_IDLE;
				nxt_st.resp_valid = 1'b1;
				nxt_st.resp[1] = st_ff.req[1];
				nxt_st.resp[2] = 16'h0000;
				nxt_st.resp[3] = 16'h0000;
				// Response header echoes the number, reserved bit low
				nxt_st.resp[0] = {RS_ERR, 1'b0, rq_pnu};
				case (rq_id)
					RQ_NONE: begin
						nxt_st.resp[0] = {RS_NONE, 1'b0, rq_pnu};
					end
					RQ_RD, RQ_FRD, RQ_DESC, RQ_CNT,
					RQ_WRW, RQ_WRD, RQ_FWRW, RQ_FWRD: begin
						if (bad_pnu) begin
							nxt_st.resp[2] = ER_PNU;
						end else if ((rq_id == RQ_WRW || rq_id == RQ_WRD
								|| rq_id == RQ_FWRW || rq_id == RQ_FWRD)
								&& !st_ff.mc_sync[1]) begin
							// No authority: answer 8, value words left zero
							nxt_st.resp[0] = {RS_AUTH, 1'b0, rq_pnu};
						end else if (rq_id == RQ_CNT) begin
							nxt_st.resp[0] = {RS_CNT, 1'b0, rq_pnu};
							nxt_st.resp[3] = 16'(N_ELEM);
						end else if (rq_id == RQ_DESC) begin
							// Element 0: double-word flag, element 1: read-only flag
							if (rq_sub > 8'h01) begin
								nxt_st.resp[2] = ER_SUB;
							end else begin
								nxt_st.resp[0] = {RS_DESC, 1'b0, rq_pnu};
								nxt_st.resp[3] = {15'h0000, eidx[0] ? is_ro : is_dw};
							end
						end else if (bad_sub) begin
							nxt_st.resp[2] = ER_SUB;
						end else if (rq_id == RQ_RD || rq_id == RQ_FRD) begin
							// Pair 1/6 does the same access; only the code differs
							if (is_dw) begin
								nxt_st.resp[0] = {(rq_id == RQ_FRD) ? RS_FD : RS_D, 1'b0,
									rq_pnu};
								nxt_st.resp[2] = cur[31:16];
								nxt_st.resp[3] = cur[15:0];
							end else begin
								nxt_st.resp[0] = {(rq_id == RQ_FRD) ? RS_FW : RS_W, 1'b0,
									rq_pnu};
								nxt_st.resp[3] = cur[15:0];
							end
						end else if (is_ro) begin
							nxt_st.resp[2] = ER_RO;
						end else if ((rq_id == RQ_WRD || rq_id == RQ_FWRD) != is_dw) begin
							// Value width must match the parameter's type
							nxt_st.resp[2] = ER_TYPE;
						end else begin
							nxt_st.changed = 1'b1;
							nxt_st.num = pidx;
							nxt_st.elem = eidx;
							if (is_dw) begin
								nxt_st.value = {st_ff.req[2], st_ff.req[3]};
								nxt_st.resp[2] = st_ff.req[2];
							end else begin
								nxt_st.value = {16'h0000, st_ff.req[3]};
							end
							nxt_st.resp[3] = st_ff.req[3];
							nxt_st.mem[{pidx, eidx}] = nxt_st.value;
							case (rq_id)
								RQ_WRW:  nxt_st.resp[0] = {RS_W, 1'b0, rq_pnu};
								RQ_WRD:  nxt_st.resp[0] = {RS_D, 1'b0, rq_pnu};
								RQ_FWRW: nxt_st.resp[0] = {RS_FW, 1'b0, rq_pnu};
								RQ_FWRD: nxt_st.resp[0] = {RS_FD, 1'b0, rq_pnu};
								default: nxt_st.resp[0] = {RS_ERR, 1'b0, rq_pnu};
							endcase
						end
					end
					default: begin
						// Unsupported identifier
						nxt_st.resp[2] = ER_REQ;
					end
				endcase
			end
			default: begin
				nxt_st.state = ST_IDLE;
			end
		endcase
	end

	// State register; parameter table clears on reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
			st_ff.state <= ST_IDLE;
			st_ff.mem <= {(N_PARAM*N_ELEM){PAR_RST}};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign link.resp_valid = st_ff.resp_valid;
	assign link.resp_words = st_ff.resp;
	assign par_changed = st_ff.changed;
	assign par_num = st_ff.num;
	assign par_elem = st_ff.elem;
	assign par_value = st_ff.value;
endmodule : pci_dev
`default_nettype wire

// [hw/pci_link_if.sv]
`timescale 1ns/100ps
`default_nettype none
// Word 0 header, word 1 element select, words 2..3 value words (2 = high)
interface pci_link_if;
	import pci_pkg::*;
	logic      req_valid;
	pci_chan_t req_words;
	logic      resp_valid;
	pci_chan_t resp_words;
	modport dev (input req_valid, input req_words, output resp_valid, output resp_words);
	modport ctl (output req_valid, output req_words, input resp_valid, input resp_words);
endinterface : pci_link_if
`default_nettype wire

// [hw/pci_pkg.sv]
package pci_pkg;
	localparam int N_WORDS   = 4;
	localparam int ID_LSB    = 12;
	localparam int RSV_BIT   = 11;
	localparam int SUB_LSB   = 8;
	localparam int N_PARAM   = 8;
	localparam int N_ELEM    = 4;
	// Request identifiers
	localparam logic [3:0] RQ_NONE = 4'h0;
	localparam logic [3:0] RQ_RD   = 4'h1;
	localparam logic [3:0] RQ_WRW  = 4'h2;
	localparam logic [3:0] RQ_WRD  = 4'h3;
	localparam logic [3:0] RQ_DESC = 4'h4;
	localparam logic [3:0] RQ_FRD  = 4'h6;
	localparam logic [3:0] RQ_FWRW = 4'h7;
	localparam logic [3:0] RQ_FWRD = 4'h8;
	localparam logic [3:0] RQ_CNT  = 4'h9;
	// Response identifiers
	localparam logic [3:0] RS_NONE = 4'h0;
	localparam logic [3:0] RS_W    = 4'h1;
	localparam logic [3:0] RS_D    = 4'h2;
	localparam logic [3:0] RS_DESC = 4'h3;
	localparam logic [3:0] RS_FW   = 4'h4;
	localparam logic [3:0] RS_FD   = 4'h5;
	localparam logic [3:0] RS_CNT  = 4'h6;
	localparam logic [3:0] RS_ERR  = 4'h7;
	localparam logic [3:0] RS_AUTH = 4'h8;
	// Error numbers
	localparam logic [15:0] ER_PNU  = 16'h0000;
	localparam logic [15:0] ER_RO   = 16'h0001;
	localparam logic [15:0] ER_SUB  = 16'h0003;
	localparam logic [15:0] ER_TYPE = 16'h0005;
	localparam logic [15:0] ER_DESC = 16'h0007;
	localparam logic [15:0] ER_REQ  = 16'h006A;
	// Parameter attributes, one bit per parameter number, then the page base and the table reset value
	localparam logic [7:0]  PAR_RO_MASK = 8'h01;
	localparam logic [7:0]  PAR_DW_MASK = 8'hF0;
	localparam logic [7:0]  PAGE_BASE   = 8'h00;
	localparam logic [31:0] PAR_RST     = 32'h0000_0000;
	// Controller register byte offsets, then bus response codes
	localparam logic [7:0] OFS_REQ  = 8'h00;
	localparam logic [7:0] OFS_VAL  = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_RSP  = 8'h10;
	localparam logic [7:0] OFS_RVAL = 8'h14;
	localparam logic [1:0] RESP_OK  = 2'b00;
	localparam logic [1:0] RESP_ERR = 2'b10;

	typedef logic [N_WORDS-1:0][15:0] pci_chan_t;

	// Identifier field of the header word
	function automatic logic [3:0] pci_id(input logic [15:0] w);
		return w[15:ID_LSB];
	endfunction : pci_id

	// Number field of the header word
	function automatic logic [10:0] pci_pnu(input logic [15:0] w);
		return w[RSV_BIT-1:0];
	endfunction : pci_pnu
endpackage : pci_pkg

// [testbench/parameter_channel_interpreter_test.sv]
`timescale 1ns/100ps
`default_nettype none
module parameter_channel_interpreter_test;
	import pci_pkg::*;
	logic        aclk, aresetn, master_ctrl, par_changed;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, par_value;
	logic [1:0]  bresp, rresp, par_elem;
	logic [2:0]  par_num;
	int          n_fail = 0, num_checks = 0, n_chg = 0, n;
	pci_link_if link();
	pci_ctl pci_ctl_i(.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link(link));
	pci_dev pci_dev_i(.aclk(aclk), .aresetn(aresetn), .master_ctrl(master_ctrl),
		.par_changed(par_changed), .par_num(par_num), .par_elem(par_elem),
		.par_value(par_value), .link(link));
	pci_link_chk pci_link_chk_i(.aclk(aclk), .aresetn(aresetn), .req_valid(link.req_valid),
		.req_words(link.req_words), .resp_valid(link.resp_valid),
		.resp_words(link.resp_words));
	// Clock and a count of change pulses
	always #4 aclk = ~aclk;
	always @(posedge aclk) if (par_changed === 1'b1) n_chg <= n_chg + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish
	// Ready is read at the falling edge, so it equals what the next rising edge samples
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_t, w_t, b_t;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
		b_t = 0;
		while (!b_t) begin
			@(negedge aclk);
			aw_t = awvalid && awready; w_t = wvalid && wready; b_t = bvalid === 1'b1; r = bresp;
			@(posedge aclk);
			if (aw_t) awvalid <= 0;
			if (w_t) wvalid <= 0;
			if (b_t) bready <= 0;
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar_t, done;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		done = 0;
		while (!done) begin
			@(negedge aclk);
			ar_t = arvalid && arready; done = rvalid === 1'b1; d = rdata; r = rresp;
			@(posedge aclk);
			if (ar_t) arvalid <= 0;
			if (done) rready <= 0;
		end
	endtask : axi_rd
	function automatic logic [15:0] hd(input logic [3:0] id, input logic [10:0] num);
		return {id, 1'b0, num};
	endfunction : hd
	// One request through the controller registers, then judge id and value words
	task automatic do_req(input logic [15:0] w0, w1, input logic [31:0] v,
		input logic [3:0] eid, input logic [31:0] ev, input logic [31:0] m = 32'hFFFF_FFFF);
		logic [31:0] d;
		logic [1:0]  r;
		axi_wr(OFS_REQ, {w1, w0}, r);
		axi_wr(OFS_VAL, v, r);
		axi_wr(OFS_CTRL, 32'h0000_0001, r);
		d = 0;
		for (int i = 0; i < 20 && d[1] !== 1'b1; i++) axi_rd(OFS_STAT, d, r);
		chk(d, 32'h0000_0002);
		axi_rd(OFS_RSP, d, r);
		chk({28'h0, d[15:12]}, {28'h0, eid});
		axi_rd(OFS_RVAL, d, r);
		chk(d & m, ev);
	endtask : do_req
	task automatic t_word();
		n = n_chg;
		do_req(hd(RQ_NONE, 1), 0, 32'h0000_5555, RS_NONE, 0);
		do_req(16'h2801, 0, 32'h0000_1234, RS_W, 32'h0000_1234);
		chk({29'h0, par_num}, 1);
		chk(par_value, 32'h0000_1234);
		do_req(hd(RQ_RD, 1), 0, 0, RS_W, 32'h0000_1234);
		do_req(hd(RQ_FWRW, 1), 16'h0200, 32'h0000_00AB, RS_FW, 32'h0000_00AB);
		chk({30'h0, par_elem}, 2);
		chk(32'(n_chg - n), 2);
		do_req(hd(RQ_FRD, 1), 16'h0200, 0, RS_FW, 32'h0000_00AB);
		do_req(hd(RQ_RD, 1), 16'h0200, 0, RS_W, 32'h0000_00AB);
	endtask : t_word
	task automatic t_dword();
		do_req(hd(RQ_WRD, 5), 0, 32'hDEAD_BEEF, RS_D, 32'hDEAD_BEEF);
		do_req(hd(RQ_FWRD, 5), 16'h0300, 32'h1357_9BDF, RS_FD, 32'h1357_9BDF);
		do_req(hd(RQ_FRD, 5), 16'h0300, 0, RS_FD, 32'h1357_9BDF);
		do_req(hd(RQ_RD, 5), 0, 0, RS_D, 32'hDEAD_BEEF);
	endtask : t_dword
	task automatic t_desc();
		do_req(hd(RQ_DESC, 5), 0, 0, RS_DESC, 1);
		do_req(hd(RQ_DESC, 0), 16'h0100, 0, RS_DESC, 1);
		do_req(hd(RQ_DESC, 1), 16'h0100, 0, RS_DESC, 0);
		do_req(hd(RQ_CNT, 3), 0, 0, RS_CNT, 32'h0000_0004);
	endtask : t_desc
	// Rejections carry the error number in the high word and change nothing
	task automatic t_err();
		n = n_chg;
		do_req(hd(RQ_FRD, 8), 0, 0, RS_ERR, {ER_PNU, 16'h0}, 32'hFFFF_0000);
		do_req(hd(RQ_FRD, 1), 16'h0001, 0, RS_ERR, {ER_PNU, 16'h0}, 32'hFFFF_0000);
		do_req(hd(RQ_FRD, 1), 16'h0400, 0, RS_ERR, {ER_SUB, 16'h0}, 32'hFFFF_0000);
		do_req(hd(RQ_WRW, 0), 0, 5, RS_ERR, {ER_RO, 16'h0}, 32'hFFFF_0000);
		do_req(hd(RQ_WRD, 1), 0, 5, RS_ERR, {ER_TYPE, 16'h0}, 32'hFFFF_0000);
		do_req(hd(RQ_DESC, 1), 16'h0200, 0, RS_ERR, {ER_SUB, 16'h0}, 32'hFFFF_0000);
		for (int i = 5; i < 16; i++) begin
			if (i == 5 || i > 9) do_req(hd(4'(i), 1), 0, 0, RS_ERR, {ER_REQ, 16'h0}, 32'hFFFF_0000);
		end
		chk(32'(n_chg - n), 0);
	endtask : t_err
	task automatic t_auth();
		@(posedge aclk);
		master_ctrl <= 0;
		n = n_chg;
		do_req(hd(RQ_FWRW, 2), 0, 32'h0000_0077, RS_AUTH, 0);
		do_req(hd(RQ_RD, 2), 0, 0, RS_W, 0);
		chk(32'(n_chg - n), 0);
		master_ctrl <= 1;
	endtask : t_auth
	task automatic t_axi();
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(8'h20, d, r);
		chk({30'h0, r}, {30'h0, RESP_ERR});
		chk(d, 0);
		axi_wr(8'h24, 32'h0000_0001, r);
		chk({30'h0, r}, {30'h0, RESP_ERR});
	endtask : t_axi
	// Main sequence after twelve cycles of reset
	initial begin
		aclk = 0; aresetn = 0; master_ctrl = 1; awvalid = 0; wvalid = 0; bready = 0;
		arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		t_word(); t_dword(); t_desc(); t_err(); t_auth(); t_axi();
		tally_and_finish();
	end
	// Watchdog well beyond the expected run of under a thousand cycles
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		tally_and_finish();
	end
endmodule : parameter_channel_interpreter_test
`default_nettype wire

// [testbench/pci_link_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module pci_link_chk
	import pci_pkg::*;
(
	input wire logic      aclk,
	input wire logic      aresetn,
	input wire logic      req_valid,
	input wire pci_chan_t req_words,
	input wire logic      resp_valid,
	input wire pci_chan_t resp_words
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Link timing: fixed two-edge answer, one-cycle pulse, words held between answers
	a_answer_two_edges: assert property (req_valid |-> ##2 resp_valid)
		else $error("answer missing two cycles after request");
	a_resp_one_pulse: assert property (resp_valid |=> !resp_valid)
		else $error("answer pulse longer than one cycle");
	a_resp_has_cause: assert property (resp_valid |-> $past(req_valid, 2))
		else $error("answer without request");
	a_words_hold: assert property (!resp_valid |-> $stable(resp_words))
		else $error("answer words changed outside an answer");
	// Header layout on both directions
	a_rsv_bit_zero: assert property (
		req_valid |-> !req_words[0][RSV_BIT] ##2 !resp_words[0][RSV_BIT])
		else $error("reserved header bit set");
	a_number_echo: assert property (
		resp_valid |-> resp_words[0][10:0] == $past(req_words[0][10:0], 2))
		else $error("number field not echoed");
	a_select_echo: assert property (
		resp_valid |-> resp_words[1] == $past(req_words[1], 2))
		else $error("element select word not echoed");
	// Answer codes tied to the request that caused them
	a_idle_zero: assert property (
		resp_valid && $past(req_words[0][15:12], 2) == RQ_NONE
		|-> resp_words[0][15:12] == RS_NONE && resp_words[3:2] == 32'h0000_0000)
		else $error("idle request gave an answer");
	a_count_reply: assert property (
		resp_valid && $past(req_words[0][15:12], 2) == RQ_CNT
		|-> resp_words[0][15:12] == RS_ERR
		|| (resp_words[0][15:12] == RS_CNT && resp_words[3] == 16'h0004))
		else $error("element count answer wrong");
	a_bad_req_err: assert property (
		resp_valid && $past(req_words[0][15:12], 2) inside {4'h5, [4'hA:4'hF]}
		|-> resp_words[0][15:12] == RS_ERR)
		else $error("unsupported request not rejected");
	c_word_change: cover property (resp_valid && resp_words[0][15:12] == RS_W);
	c_err_answer: cover property (resp_valid && resp_words[0][15:12] == RS_ERR);
	c_auth_answer: cover property (resp_valid && resp_words[0][15:12] == RS_AUTH);
endmodule : pci_link_chk
`default_nettype wire
